// file: shared/tei_pkg.sv
// package: register map, field layout and codes of the timer event/irq/status slice
package tei_pkg;

    // register word indices (printed offsets are multiples of four, so index*4)
    localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h0C;
    localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h0D;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0E;
    localparam logic [7:0] IDX_UNIT_STATE = 8'h0F;
    localparam logic [7:0] IDX_EVENT_CTRL = 8'h0A;
    localparam logic [7:0] IDX_CAPTURE_ZERO = 8'h18;
    localparam logic [7:0] IDX_CAPTURE_ONE = 8'h19;
    localparam logic [7:0] IDX_SYNC_CTRL = 8'h20;

    // field positions
    localparam int BIT_WRAP = 0;
    localparam int BIT_ERR = 1;
    localparam int BIT_SYNC = 3;
    localparam int BIT_HIT0 = 4;
    localparam int BIT_STOPPED = 3;
    localparam int BIT_CLIENT = 4;
    localparam int BIT_PENDING = 7;
    localparam int BIT_POL_INV = 4;
    localparam int BIT_EV_EN = 5;
    localparam int BIT_ONESHOT = 0;
    localparam int BIT_STOP_CMD = 1;
    localparam int BIT_START_CMD = 2;

    // reset values and masks
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_STATE = 8'h08;
    localparam logic [7:0] IRQ_MASK = 8'h3B;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;

    // transfer time between domains, in clock cycles
    localparam logic [2:0] SYNC_CYCLES = 3'h4;

    typedef enum logic [2:0] {
        TEI_ACT_OFF = 3'h0,
        TEI_ACT_RETRIGGER = 3'h1,
        TEI_ACT_COUNT = 3'h2,
        TEI_ACT_START = 3'h3,
        TEI_ACT_RSVD4 = 3'h4,
        TEI_ACT_PERIOD_WIDTH = 3'h5,
        TEI_ACT_WIDTH_PERIOD = 3'h6,
        TEI_ACT_RSVD7 = 3'h7
    } tei_action_t;

    // strobes from the counter core
    typedef struct packed {
        logic wrap;
        logic [1:0] match;
        logic halted_by_cmd;
        logic oneshot_wrap;
        logic host_32bit;
    } tei_core_evt_t;

    // event decode towards the counter core
    typedef struct packed {
        logic retrigger;
        logic count_step;
        logic start;
    } tei_core_cmd_t;

endpackage

// file: design/tei_top.sv
// timer event input, interrupt enables/flags, status and capture slots
// Behaviour
// - polarity invert bit set inverts the incoming event before use
// - action 0 none, 1 retrigger, 2 count per event, 3 start
// - action 5: period to slot zero, pulse width to slot one
// - action 6: period to slot one, pulse width to slot zero
// - writing one to enable-clear view clears that enable
// - writing one to enable-set view sets that enable
// - both views read the same shared enable bits
// - channel hit flag set one cycle after match or capture
// - hit flag requests interrupt only while its enable is one
// - writing one to a hit flag clears it
// - reading a capture slot clears that channel's hit flag while capture_en_i is high
// - capture onto a still-set hit flag sets the error flag
// - writing one to the error flag clears it
// - wrap flag set one cycle after overflow whatever its enable; only its interrupt request is gated by the enable
// - writing one to the wrap flag clears it
// - sync done interrupt enabled by set view, disabled by clear view
// - transfer pending bit high while a domain transfer runs
// - events are acted on only while event input enable is one
// - stopped bit set on stop command, or on one-shot wrap while oneshot is one
// - client bit reads one while the host counter runs 32-bit mode
//
// Added by the designer: register access over Avalon-MM.
module tei_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // asynchronous event input
    input wire logic event_i,
    // counter core side
    input wire tei_pkg::tei_core_evt_t core_evt_i,
    input wire logic [15:0] count_value_i,
    input wire logic capture_en_i,
    output tei_pkg::tei_core_cmd_t core_cmd_o,
    output logic oneshot_o,
    // interrupt
    output logic irq_o
);

    logic ev_meta;
    logic ev_sync;
    logic ev_prev;
    logic [7:0] event_ctrl;
    logic [7:0] irq_enable;
    logic [7:0] irq_flags;
    logic stopped;
    logic client;
    logic oneshot;
    logic [2:0] sync_cnt;
    logic [15:0] capture_slot [2];
    logic [15:0] period_start;
    logic [15:0] width_start;
    logic rd_ack;
    logic wr_hit;
    logic [7:0] wdat;
    logic ev_level;
    logic ev_rise;
    logic ev_fall;
    logic ev_on;
    tei_pkg::tei_action_t action;
    logic [1:0] cap_strobe;
    logic [1:0] cap_read;
    logic [15:0] next_cap [2];
    logic next_rd;

    ////////////////////////////////////////////////////////////////////////
    // event input path

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_prev <= 1'b0;
        end
        else
        begin
            ev_meta <= event_i;
            ev_sync <= ev_meta;
            ev_prev <= ev_level;
        end
    end

    // polarity inversion
    // flipping the invert bit while enabled looks like an edge: set polarity before enabling
    assign ev_level = ev_sync ^ event_ctrl[tei_pkg::BIT_POL_INV];
    assign ev_on = event_ctrl[tei_pkg::BIT_EV_EN];
    assign ev_rise = ev_on & ev_level & ~ev_prev;
    assign ev_fall = ev_on & ~ev_level & ev_prev;
    assign action = tei_pkg::tei_action_t'(event_ctrl[2:0]);

    // action decode; reserved codes fall to no action
    always_comb
    begin
        core_cmd_o = '0;
        case (action)
            tei_pkg::TEI_ACT_RETRIGGER: core_cmd_o.retrigger = ev_rise;
            tei_pkg::TEI_ACT_COUNT: core_cmd_o.count_step = ev_rise;
            tei_pkg::TEI_ACT_START: core_cmd_o.start = ev_rise;
            default: core_cmd_o = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // period / pulse width capture

    always_comb
    begin
        cap_strobe = 2'b00;
        next_cap[0] = capture_slot[0];
        next_cap[1] = capture_slot[1];
        // period to slot zero, width to slot one
        if (action == tei_pkg::TEI_ACT_PERIOD_WIDTH)
        begin
            if (ev_rise)
            begin
                next_cap[0] = 16'(count_value_i - period_start);
                cap_strobe[0] = 1'b1;
            end
            if (ev_fall)
            begin
                next_cap[1] = 16'(count_value_i - width_start);
                cap_strobe[1] = 1'b1;
            end
        end
        // period to slot one, width to slot zero
        else if (action == tei_pkg::TEI_ACT_WIDTH_PERIOD)
        begin
            if (ev_rise)
            begin
                next_cap[1] = 16'(count_value_i - period_start);
                cap_strobe[1] = 1'b1;
            end
            if (ev_fall)
            begin
                next_cap[0] = 16'(count_value_i - width_start);
                cap_strobe[0] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            period_start <= tei_pkg::RST_CAPTURE;
            width_start <= tei_pkg::RST_CAPTURE;
            capture_slot[0] <= tei_pkg::RST_CAPTURE;
            capture_slot[1] <= tei_pkg::RST_CAPTURE;
        end
        else
        begin
            // both period and width are timed from the rising edge
            if (ev_rise)
            begin
                period_start <= count_value_i;
                width_start <= count_value_i;
            end
            capture_slot[0] <= next_cap[0];
            capture_slot[1] <= next_cap[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus access: single-cycle write, reads answered one cycle later
    // the wait state lets a capture read clear its flag in the same edge that latches the data

    assign wr_hit = avs_write_i & avs_byteenable_i[0];
    assign wdat = avs_writedata_i[7:0];
    assign next_rd = avs_read_i & ~rd_ack;
    assign avs_waitrequest_o = avs_read_i & ~rd_ack;

    // capture read clears the hit flag, only in capture operation
    always_comb
    begin
        cap_read = 2'b00;
        if (next_rd & capture_en_i)
        begin
            if (avs_address_i == tei_pkg::IDX_CAPTURE_ZERO)
                cap_read[0] = 1'b1;
            else if (avs_address_i == tei_pkg::IDX_CAPTURE_ONE)
                cap_read[1] = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rd_ack <= 1'b0;
            avs_readdata_o <= '0;
        end
        else
        begin
            rd_ack <= next_rd;
            if (next_rd)
            begin
                // both views return the shared enables
                if (avs_address_i == tei_pkg::IDX_IRQ_ENABLE_CLEAR)
                    avs_readdata_o <= {24'h000000, irq_enable};
                else if (avs_address_i == tei_pkg::IDX_IRQ_ENABLE_SET)
                    avs_readdata_o <= {24'h000000, irq_enable};
                else if (avs_address_i == tei_pkg::IDX_IRQ_FLAGS)
                    avs_readdata_o <= {24'h000000, irq_flags};
                else if (avs_address_i == tei_pkg::IDX_UNIT_STATE)
                    avs_readdata_o <= {24'h000000, (sync_cnt != 3'h0), 2'b00, client, stopped, 3'b000};
                else if (avs_address_i == tei_pkg::IDX_EVENT_CTRL)
                    avs_readdata_o <= {24'h000000, event_ctrl};
                else if (avs_address_i == tei_pkg::IDX_CAPTURE_ZERO)
                    avs_readdata_o <= {16'h0000, capture_slot[0]};
                else if (avs_address_i == tei_pkg::IDX_CAPTURE_ONE)
                    avs_readdata_o <= {16'h0000, capture_slot[1]};
                else if (avs_address_i == tei_pkg::IDX_SYNC_CTRL)
                    avs_readdata_o <= {31'h00000000, oneshot};
                else
                    avs_readdata_o <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            event_ctrl <= 8'h00;
        else if (wr_hit && avs_address_i == tei_pkg::IDX_EVENT_CTRL)
            event_ctrl <= wdat & 8'h37;
    end

    // set and clear views on one enable set
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            irq_enable <= tei_pkg::RST_ENABLE;
        else if (wr_hit && avs_address_i == tei_pkg::IDX_IRQ_ENABLE_CLEAR)
            irq_enable <= irq_enable & ~(wdat & tei_pkg::IRQ_MASK);
        else if (wr_hit && avs_address_i == tei_pkg::IDX_IRQ_ENABLE_SET)
            irq_enable <= irq_enable | (wdat & tei_pkg::IRQ_MASK);
    end

    ////////////////////////////////////////////////////////////////////////
    // domain transfer, oneshot and stop/start commands

    // pending while a control write is carried across
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sync_cnt <= 3'h0;
        else if (wr_hit && avs_address_i == tei_pkg::IDX_SYNC_CTRL)
            sync_cnt <= tei_pkg::SYNC_CYCLES;
        else if (sync_cnt != 3'h0)
            sync_cnt <= sync_cnt - 3'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            oneshot <= 1'b0;
        else if (wr_hit && avs_address_i == tei_pkg::IDX_SYNC_CTRL)
            oneshot <= wdat[tei_pkg::BIT_ONESHOT];
    end
    assign oneshot_o = oneshot;

    // stopped on stop command or, while oneshot is one, one-shot wrap; start clears
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            stopped <= tei_pkg::RST_STATE[tei_pkg::BIT_STOPPED];
        else if (core_evt_i.halted_by_cmd | (core_evt_i.oneshot_wrap & oneshot))
            stopped <= 1'b1;
        else if (core_cmd_o.retrigger | core_cmd_o.start)
            stopped <= 1'b0;
    end

    // client bit follows the host's 32-bit mode
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            client <= 1'b0;
        else
            client <= core_evt_i.host_32bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags: a set in the clearing cycle wins

    logic flag_wr;
    logic sync_done;
    logic err_flag;
    logic wrap_flag;
    logic sync_flag;
    assign flag_wr = wr_hit && avs_address_i == tei_pkg::IDX_IRQ_FLAGS;
    assign sync_done = (sync_cnt == 3'h1);

    // each flag lives in its own register so that no two processes write one variable
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            logic hit;
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                    hit <= 1'b0;
                // set one cycle after match or capture
                else if (core_evt_i.match[ch] | cap_strobe[ch])
                    hit <= 1'b1;
                else if ((flag_wr & wdat[tei_pkg::BIT_HIT0 + ch]) | cap_read[ch])
                    hit <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            err_flag <= 1'b0;
        else if (|(cap_strobe & irq_flags[tei_pkg::BIT_HIT0 +: 2]))
            err_flag <= 1'b1;
        else if (flag_wr & wdat[tei_pkg::BIT_ERR])
            err_flag <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            wrap_flag <= 1'b0;
        else if (core_evt_i.wrap)
            wrap_flag <= 1'b1;
        else if (flag_wr & wdat[tei_pkg::BIT_WRAP])
            wrap_flag <= 1'b0;
    end

    // sync done raised as the transfer count ends
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sync_flag <= 1'b0;
        else if (sync_done)
            sync_flag <= 1'b1;
        else if (flag_wr & wdat[tei_pkg::BIT_SYNC])
            sync_flag <= 1'b0;
    end

    // unused flag positions read as zero
    assign irq_flags = {
        2'b00,
        g_chan[1].hit,
        g_chan[0].hit,
        sync_flag,
        1'b0,
        err_flag,
        wrap_flag
    };

    assign irq_o = |(irq_flags & irq_enable);

endmodule

// file: tb/tei_top_properties.sv
// concurrent checks on the ports of the timer event and interrupt slice
module tei_top_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register bus
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // core side and interrupt
    input wire tei_pkg::tei_core_cmd_t core_cmd_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////
    a_write_no_wait:
        assert property (avs_write_i |-> !avs_waitrequest_o) else $error("write stalled");
    a_read_first_wait:
        assert property (avs_read_i && !$past(avs_read_i) |-> avs_waitrequest_o) else $error("read not stalled");
    a_read_one_wait:
        assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read stalled twice");
    a_idle_no_wait:
        assert property (!avs_read_i |-> !avs_waitrequest_o) else $error("idle wait");
    a_readdata_hold:
        assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("read data moved");
    // only the low byte of a byte register carries data
    a_byte_regs_narrow:
        assert property (avs_read_i && !avs_waitrequest_o && (avs_address_i inside {8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F})
            |-> avs_readdata_o[31:8] == 24'h000000) else $error("upper bits set");
    a_unmapped_zero:
        assert property (avs_read_i && !avs_waitrequest_o
            && !(avs_address_i inside {8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h18, 8'h19, 8'h20})
            |-> avs_readdata_o == 32'h00000000) else $error("unmapped read not zero");
    a_cmd_exclusive:
        assert property ($onehot0(core_cmd_o)) else $error("two commands at once");
    a_cmd_one_pulse:
        assert property (core_cmd_o != 3'h0 |=> core_cmd_o == 3'h0) else $error("command pulse too long");
    a_irq_after_reset:
        assert property ($fell(srst_i) |-> !irq_o) else $error("interrupt after reset");
endmodule
////////////////////////////////////////////////////////////
bind tei_top tei_top_properties i_tei_top_properties (.clk_i(clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .core_cmd_o(core_cmd_o), .irq_o(irq_o));

// file: tb/tei_top_bench.sv
// self-checking testbench for the timer event and interrupt slice
module tei_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic event_i = 1'b0;
    tei_pkg::tei_core_evt_t core_evt_i = '0;
    logic [15:0] count_value_i = 16'h0000;
    logic capture_en_i = 1'b0;
    tei_pkg::tei_core_cmd_t core_cmd_o;
    logic oneshot_o;
    logic irq_o;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [2:0] seen;
    logic [2:0] e;
    always #50 clk_i = ~clk_i;
    tei_top i_tei_top (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .event_i(event_i), .core_evt_i(core_evt_i),
        .count_value_i(count_value_i), .capture_en_i(capture_en_i), .core_cmd_o(core_cmd_o),
        .oneshot_o(oneshot_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, ex, got);
        end
    endtask
    // bus request held until waitrequest is seen low at a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        avs_write_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        chk(n, ex, avs_readdata_o);
        avs_read_i <= 1'b0;
    endtask
    task automatic chk_irq(input logic ex);
        @(negedge clk_i);
        chk("irq", {31'h0, ex}, {31'h0, irq_o});
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clk_i);
        core_evt_i <= v;
        @(posedge clk_i);
        core_evt_i <= '0;
    endtask
    // synchroniser plus decode take a few cycles, so collect over a window
    task automatic ev(input logic lvl);
        @(posedge clk_i);
        event_i <= lvl;
        seen = 3'h0;
        repeat (6) @(negedge clk_i) seen = seen | core_cmd_o;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        rc("enable clear", 8'h0C, 32'h00);
        rc("enable set", 8'h0D, 32'h00);
        rc("flags", 8'h0E, 32'h00);
        rc("state", 8'h0F, 32'h08);
        $display("reset test done");
    endtask
    task automatic t_enables();
        wr(8'h0D, 8'h3B, 4'h1);
        rc("enable clear", 8'h0C, 32'h3B);
        wr(8'h0C, 8'h09, 4'h1);
        rc("enable set", 8'h0D, 32'h32);
        wr(8'h0D, 8'h00, 4'h1);
        wr(8'h0D, 8'h01, 4'h0);
        rc("enable clear", 8'h0C, 32'h32);
        rc("unmapped", 8'h40, 32'h00);
        $display("enable test done");
    endtask
    task automatic t_wrap();
        wr(8'h0C, 8'hFF, 4'h1);
        wr(8'h0D, 8'h01, 4'h1);
        pulse(6'h20);
        rc("flags", 8'h0E, 32'h01);
        chk_irq(1'b1);
        wr(8'h0C, 8'h01, 4'h1);
        chk_irq(1'b0);
        wr(8'h0E, 8'h00, 4'h1);
        rc("flags", 8'h0E, 32'h01);
        wr(8'h0E, 8'h01, 4'h1);
        rc("flags", 8'h0E, 32'h00);
        $display("wrap test done");
    endtask
    task automatic t_match();
        pulse(6'h10);
        rc("flags", 8'h0E, 32'h20);
        chk_irq(1'b0);
        wr(8'h0D, 8'h20, 4'h1);
        chk_irq(1'b1);
        wr(8'h0E, 8'h20, 4'h1);
        rc("flags", 8'h0E, 32'h00);
        chk_irq(1'b0);
        wr(8'h0C, 8'h20, 4'h1);
        $display("match test done");
    endtask
    task automatic t_events();
        for (int a = 0; a < 8; a++)
        begin
            e = (a == 1) ? 3'h4 : (a == 2) ? 3'h2 : (a == 3) ? 3'h1 : 3'h0;
            wr(8'h0A, 8'h20 | 8'(a), 4'h1);
            ev(1'b1);
            chk("cmd rise", {29'h0, e}, {29'h0, seen});
            ev(1'b0);
            chk("cmd fall", 32'h0, {29'h0, seen});
        end
        wr(8'h0A, 8'h02, 4'h1);
        ev(1'b1);
        chk("cmd disabled", 32'h0, {29'h0, seen});
        wr(8'h0A, 8'h32, 4'h1);
        ev(1'b0);
        chk("cmd inverted", 32'h2, {29'h0, seen});
        ev(1'b1);
        chk("cmd inverted", 32'h0, {29'h0, seen});
        wr(8'h0A, 8'h00, 4'h1);
        ev(1'b0);
        $display("event test done");
    endtask
    task automatic t_status();
        rc("state", 8'h0F, 32'h00);
        // one-shot wrap with one-shot off must not stop the counter
        pulse(6'h02);
        rc("state", 8'h0F, 32'h00);
        pulse(6'h04);
        rc("state", 8'h0F, 32'h08);
        @(posedge clk_i);
        core_evt_i <= 6'h01;
        rc("state", 8'h0F, 32'h18);
        core_evt_i <= '0;
        $display("status test done");
    endtask
    task automatic t_capture();
        wr(8'h0E, 8'h3B, 4'h1);
        capture_en_i <= 1'b1;
        count_value_i <= 16'h1234;
        wr(8'h0A, 8'h25, 4'h1);
        // previous rise was at count zero, so the period is 0x1234
        ev(1'b1);
        // width 0x0456 after the rise at 0x1234
        count_value_i <= 16'h168A;
        ev(1'b0);
        rc("flags", 8'h0E, 32'h30);
        rc("slot zero", 8'h18, 32'h1234);
        rc("flags", 8'h0E, 32'h20);
        rc("slot one", 8'h19, 32'h0456);
        ev(1'b1);
        ev(1'b0);
        ev(1'b1);
        rc("flags", 8'h0E, 32'h32);
        wr(8'h0E, 8'h02, 4'h1);
        rc("flags", 8'h0E, 32'h30);
        wr(8'h0A, 8'h26, 4'h1);
        wr(8'h0E, 8'h3B, 4'h1);
        // period 0x0ABC after the rise at 0x168A, then width 0x0DEF
        count_value_i <= 16'h2146;
        ev(1'b0);
        ev(1'b1);
        count_value_i <= 16'h2F35;
        ev(1'b0);
        rc("slot one", 8'h19, 32'h0ABC);
        rc("slot zero", 8'h18, 32'h0DEF);
        $display("capture test done");
    endtask
    task automatic t_sync();
        wr(8'h0E, 8'h3B, 4'h1);
        wr(8'h0D, 8'h08, 4'h1);
        wr(8'h20, 8'h01, 4'h1);
        rc("state", 8'h0F, 32'h88);
        repeat (6) @(posedge clk_i);
        rc("state", 8'h0F, 32'h08);
        rc("flags", 8'h0E, 32'h08);
        chk_irq(1'b1);
        chk("oneshot", 32'h1, {31'h0, oneshot_o});
        wr(8'h0E, 8'h08, 4'h1);
        chk_irq(1'b0);
        // a start event runs the counter again, a one-shot wrap stops it
        wr(8'h0A, 8'h23, 4'h1);
        ev(1'b1);
        rc("state", 8'h0F, 32'h00);
        pulse(6'h02);
        rc("state", 8'h0F, 32'h08);
        ev(1'b0);
        $display("sync test done");
    endtask
    ////////////////////////////////////////////////////////////
    // whole run is well under a thousand cycles; the ceiling only cuts a hang
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_enables();
        t_wrap();
        t_match();
        t_events();
        t_status();
        t_capture();
        t_sync();
        summarize();
    end
endmodule
